// [logic/xbp_bus_pins.v]
// Overview of operation
// R1: nonmux address leads muxed address half period
// R2: nonmux address floats in hold or reset
// R3: low address byte on muxed pins in t1
// R4: write data on muxed pins t2 to t4
// R5: read data captured at end of t3
// R6: show internal read data during t3, t4
// R7: no low strobe: muxed pins float t2-t4
// R8: muxed pins float in hold or reset
// R9: reset release latches muxed pins into config
// R10: strap low locks status pins to bus use
// R11: 8-bit data: low pins plus upper address pins
// R12: disabled address phase on lower/upper selects
// R13: address strap sampled within three clocks
// R14: muxed address valid at latch strobe fall
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "xbp_map.vh"

module xbp_bus_pins #(
    parameter AW     = 20,
    parameter DW     = 8,
    parameter FDEPTH = 8,
    parameter FAW    = 3
) (
    input  wire          CLK,
    input  wire          SYS_RST,
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output reg           PREADY,
    output reg           PSLVERR,
    input  wire          RESET_INPUT_N,
    input  wire          BUS_HOLD_REQ,
    output reg           BUS_HOLD_ACK,
    output reg           PRIMARY_CLOCK_OUT,
    output reg  [AW-1:0] NONMUX_ADDRESS_BUS,
    output reg           NONMUX_ADDRESS_OE,
    input  wire [DW-1:0] MUXED_ADDR_DATA_LOW_IN,
    output reg  [DW-1:0] MUXED_ADDR_DATA_LOW_OUT,
    output reg           MUXED_ADDR_DATA_LOW_OE,
    input  wire [7:0]    UPPER_ADDRESS_ONLY_BUS_IN,
    output reg  [7:0]    UPPER_ADDRESS_ONLY_BUS_OUT,
    output reg           UPPER_ADDRESS_ONLY_BUS_OE,
    output reg           ADDR_LATCH_ENABLE,
    output reg           READ_STROBE_N,
    output reg           LOW_BYTE_WRITE_STROBE_N,
    input  wire          ADDRESS_PHASE_STRAP,
    input  wire          SHOW_READ_STRAP_N,
    output reg           STATUS_SIX_OUT,
    output reg           UPPER_ZERO_INDICATOR
);
    // one-hot bus cycle states, each t-state is one clock-out period
    localparam S_IDLE = 5'b00001;
    localparam S_T1   = 5'b00010;
    localparam S_T2   = 5'b00100;
    localparam S_T3   = 5'b01000;
    localparam S_T4   = 5'b10000;

    reg  [4:0]               state;
    reg  [4:0]               next_state;
    reg                      ph;
    reg  [`XBP_CTRL_W-1:0]   ctrl;
    reg  [DW-1:0]            wdata;
    reg  [24:0]              cmd;
    reg                      pending;
    reg  [AW-1:0]            cyc_addr;
    reg                      cyc_write;
    reg                      cyc_lane;
    reg                      cyc_int;
    reg                      cyc_noaddr;
    reg                      hold_grant;
    reg                      res_prev;
    reg  [15:0]              config_reg;
    reg                      address_phase_strap_strap;
    reg                      show_strap_n;
    wire                     rst_cond;
    wire                     acc;
    wire                     setup;
    wire                     launch;
    wire                     show_en;
    wire                     pio6_ok;
    wire                     pioz_ok;
    wire                     cmd_noaddr;
    wire                     capture;
    wire [DW-1:0]            fifo_out;
    wire                     fifo_valid;
    wire                     fifo_in_ready;
    wire                     fifo_pop;
    wire [DW-1:0]            cap_data;

    // register decode is used by the read mux and the write path
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = hit(addr, `XBP_OFF_CTRL) | hit(addr, `XBP_OFF_CMD) | hit(addr, `XBP_OFF_WDATA)
                   | hit(addr, `XBP_OFF_RDATA) | hit(addr, `XBP_OFF_STATUS) | hit(addr, `XBP_OFF_CONFIG);
        end
    endfunction

    // reset pin low is a reset condition for the pins, clock out keeps running
    assign rst_cond   = SYS_RST | ~RESET_INPUT_N;
    assign setup      = PSEL & ~PENABLE;
    assign acc        = PSEL & PENABLE & PREADY;
    assign show_en    = ~show_strap_n | ctrl[`XBP_CTRL_SHOW];
    // general io use only allowed when the strap was high at reset
    assign pio6_ok    = address_phase_strap_strap & ctrl[`XBP_CTRL_PIO6];                           // [R10]
    assign pioz_ok    = address_phase_strap_strap & ctrl[`XBP_CTRL_PIOZ];                           // [R10]
    assign cmd_noaddr = address_phase_strap_strap & ctrl[`XBP_CTRL_DISADDR]
                      & ((cmd[`XBP_CMD_SEL_HI:`XBP_CMD_SEL_LO] == `XBP_SEL_LOWER)
                      |  (cmd[`XBP_CMD_SEL_HI:`XBP_CMD_SEL_LO] == `XBP_SEL_UPPER));  // [R12]
    // a read only starts while the fifo has room, so a full fifo stalls the bus
    assign launch     = (state == S_IDLE) & ph & pending & ~hold_grant & ~BUS_HOLD_REQ
                      & (cmd[`XBP_CMD_WRITE] | fifo_in_ready) & ~rst_cond;
    // pins lag state by one cycle, so this cycle's pins are the last half of t3
    assign capture    = (state == S_T4) & ~ph & ~cyc_write;                          // [R5]
    assign cap_data   = cyc_int ? wdata : MUXED_ADDR_DATA_LOW_IN;
    assign fifo_pop   = acc & ~PWRITE & hit(PADDR, `XBP_OFF_RDATA);

    xbp_fifo #(
        .WIDTH (DW),
        .DEPTH (FDEPTH),
        .AW    (FAW)
    ) u_fifo (
        .CLK       (CLK),
        .SYS_RST   (SYS_RST),
        .IN_DATA   (cap_data),
        .IN_VALID  (capture),
        .IN_READY  (fifo_in_ready),
        .OUT_DATA  (fifo_out),
        .OUT_VALID (fifo_valid),
        .OUT_READY (fifo_pop)
    );

    // t-state sequencing, one state step per full clock-out period
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE: if (launch) next_state = S_T1;
            S_T1:   if (ph) next_state = S_T2;
            S_T2:   if (ph) next_state = S_T3;
            S_T3:   if (ph) next_state = S_T4;
            S_T4:   if (ph) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge CLK)
    begin
        if (SYS_RST)
            ph <= 1'b0;
        else
            ph <= ~ph;
    end

    // bus cycle state; a reset condition aborts any cycle in flight
    always @(posedge CLK)
    begin
        if (rst_cond)
        begin
            state      <= S_IDLE;
            cyc_addr   <= `XBP_ADDR_RST;
            cyc_write  <= 1'b0;
            cyc_lane   <= 1'b0;
            cyc_int    <= 1'b0;
            cyc_noaddr <= 1'b0;
            hold_grant <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (launch)
            begin
                cyc_addr   <= cmd[`XBP_CMD_ADDR_HI:0];
                cyc_write  <= cmd[`XBP_CMD_WRITE];
                cyc_lane   <= cmd[`XBP_CMD_LANE];
                cyc_int    <= cmd[`XBP_CMD_INTMEM];
                cyc_noaddr <= cmd_noaddr;
            end
            // hold is granted only between cycles and wins over a pending command
            if ((state == S_IDLE) & ph & BUS_HOLD_REQ)
                hold_grant <= 1'b1;
            else if (~BUS_HOLD_REQ)
                hold_grant <= 1'b0;
        end
    end

    // reset configuration and strap capture at the rising edge of the reset pin
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            res_prev     <= 1'b0;
            config_reg   <= `XBP_CFG_RST;
            address_phase_strap_strap   <= 1'b1;
            show_strap_n <= 1'b1;
        end
        else
        begin
            res_prev <= RESET_INPUT_N;
            if (RESET_INPUT_N & ~res_prev)
            begin
                config_reg   <= {UPPER_ADDRESS_ONLY_BUS_IN, MUXED_ADDR_DATA_LOW_IN};  // [R9] [R11]
                address_phase_strap_strap   <= ADDRESS_PHASE_STRAP;                                 // [R13]
                show_strap_n <= SHOW_READ_STRAP_N;
            end
        end
    end

    // software registers; the command is refused while one is still pending
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ctrl    <= `XBP_CTRL_RST;
            wdata   <= `XBP_DATA_RST;
            cmd     <= 25'h0000000;
            pending <= 1'b0;
        end
        else
        begin
            if (acc & PWRITE & hit(PADDR, `XBP_OFF_CTRL))
                ctrl <= PWDATA[`XBP_CTRL_W-1:0];
            if (acc & PWRITE & hit(PADDR, `XBP_OFF_WDATA))
                wdata <= PWDATA[DW-1:0];
            if (~RESET_INPUT_N | launch)
                pending <= 1'b0;
            else if (acc & PWRITE & hit(PADDR, `XBP_OFF_CMD) & ~PSLVERR)
            begin
                cmd     <= PWDATA[24:0];
                pending <= 1'b1;
            end
        end
    end

    // apb answer: registered one cycle after setup, so every access takes two cycles
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end
        else
        begin
            PREADY  <= setup;
            PSLVERR <= setup & (~mapped(PADDR) | (PWRITE & hit(PADDR, `XBP_OFF_CMD) & pending));
            PRDATA  <= 32'h00000000;
            if (setup & ~PWRITE)
            begin
                if (hit(PADDR, `XBP_OFF_CTRL))
                    PRDATA[`XBP_CTRL_W-1:0] <= ctrl;
                else if (hit(PADDR, `XBP_OFF_CMD))
                    PRDATA[24:0] <= cmd;
                else if (hit(PADDR, `XBP_OFF_WDATA))
                    PRDATA[DW-1:0] <= wdata;
                else if (hit(PADDR, `XBP_OFF_RDATA))
                    PRDATA[`XBP_RD_VALID:0] <= {fifo_valid, fifo_valid ? fifo_out : `XBP_DATA_RST};
                else if (hit(PADDR, `XBP_OFF_STATUS))
                    PRDATA[`XBP_ST_CYCLE:0] <= {~state[0], ~fifo_in_ready, ~fifo_valid,
                                                show_strap_n, address_phase_strap_strap, hold_grant, pending};
                else if (hit(PADDR, `XBP_OFF_CONFIG))
                    PRDATA[15:0] <= config_reg;
            end
        end
    end

    // pin stage: every pin is a flop that shows the previous cycle's state
    always @(posedge CLK)
    begin
        PRIMARY_CLOCK_OUT <= ~ph;
        if (rst_cond)
        begin
            BUS_HOLD_ACK               <= 1'b0;
            NONMUX_ADDRESS_BUS         <= `XBP_ADDR_RST;
            NONMUX_ADDRESS_OE          <= 1'b0;                                      // [R2]
            MUXED_ADDR_DATA_LOW_OUT    <= `XBP_DATA_RST;
            MUXED_ADDR_DATA_LOW_OE     <= 1'b0;                                      // [R8]
            UPPER_ADDRESS_ONLY_BUS_OUT <= 8'h00;
            UPPER_ADDRESS_ONLY_BUS_OE  <= 1'b0;
            ADDR_LATCH_ENABLE          <= 1'b0;
            READ_STROBE_N              <= 1'b1;
            LOW_BYTE_WRITE_STROBE_N    <= 1'b1;
            STATUS_SIX_OUT             <= 1'b0;
            UPPER_ZERO_INDICATOR       <= 1'b1;
        end
        else
        begin
            BUS_HOLD_ACK <= hold_grant;
            // nonmux address taken from the command at launch, half a period ahead
            NONMUX_ADDRESS_BUS <= launch ? cmd[`XBP_CMD_ADDR_HI:0] : cyc_addr;       // [R1]
            NONMUX_ADDRESS_OE  <= ~hold_grant;                                       // [R2]
            UPPER_ADDRESS_ONLY_BUS_OUT <= cyc_addr[15:8];                            // [R11]
            UPPER_ADDRESS_ONLY_BUS_OE  <= ~hold_grant;
            // latch strobe falls mid t1 while the muxed address still stands
            ADDR_LATCH_ENABLE <= (state == S_T1) & ~ph & ~cyc_noaddr;                // [R14]
            READ_STROBE_N     <= ~(((state == S_T2) | (state == S_T3)) & ~cyc_write);
            LOW_BYTE_WRITE_STROBE_N <= ~(((state == S_T2) | (state == S_T3)) & cyc_write & cyc_lane);
            STATUS_SIX_OUT       <= pio6_ok ? ctrl[`XBP_CTRL_VAL6] : 1'b0;          // [R10]
            UPPER_ZERO_INDICATOR <= pioz_ok ? ctrl[`XBP_CTRL_VALZ] : 1'b1;          // [R10]
            MUXED_ADDR_DATA_LOW_OUT <= `XBP_DATA_RST;
            MUXED_ADDR_DATA_LOW_OE  <= 1'b0;                                         // [R8]
            case (state)
                S_T1:
                begin
                    MUXED_ADDR_DATA_LOW_OUT <= cyc_addr[DW-1:0];                     // [R3]
                    MUXED_ADDR_DATA_LOW_OE  <= ~cyc_noaddr;                          // [R12]
                end
                S_T2:
                begin
                    MUXED_ADDR_DATA_LOW_OUT <= wdata;
                    MUXED_ADDR_DATA_LOW_OE  <= cyc_write & cyc_lane;                 // [R4] [R7]
                end
                S_T3, S_T4:
                begin
                    MUXED_ADDR_DATA_LOW_OUT <= wdata;
                    // low-byte writes drive data; internal reads are mirrored when show is on
                    MUXED_ADDR_DATA_LOW_OE  <= (cyc_write & cyc_lane)                // [R4] [R7]
                                             | (~cyc_write & cyc_int & show_en);     // [R6]
                end
                default:
                begin
                    MUXED_ADDR_DATA_LOW_OUT <= `XBP_DATA_RST;
                    MUXED_ADDR_DATA_LOW_OE  <= 1'b0;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// [logic/xbp_fifo.v]
`timescale 1ns/100ps
`default_nettype none

module xbp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             CLK,
    input  wire             SYS_RST,
    input  wire [WIDTH-1:0] IN_DATA,
    input  wire             IN_VALID,
    output wire             IN_READY,
    output wire [WIDTH-1:0] OUT_DATA,
    output wire             OUT_VALID,
    input  wire             OUT_READY
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      count;
    wire             push;
    wire             pop;

    // full and empty come from the count so depth need not be a power of two
    assign IN_READY  = (count != DEPTH[AW:0]);
    assign OUT_VALID = (count != {(AW+1){1'b0}});
    assign OUT_DATA  = mem[rd_ptr];
    assign push      = IN_VALID & IN_READY;
    assign pop       = OUT_VALID & OUT_READY;

    // storage written by index
    always @(posedge CLK)
    begin
        if (push)
            mem[wr_ptr] <= IN_DATA;
    end

    // pointers wrap at depth
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule

`default_nettype wire

// [logic/xbp_map.vh]
`ifndef XBP_MAP_VH
`define XBP_MAP_VH

// register byte offsets on the apb slave
`define XBP_OFF_CTRL      8'h00
`define XBP_OFF_CMD       8'h04
`define XBP_OFF_WDATA     8'h08
`define XBP_OFF_RDATA     8'h0c
`define XBP_OFF_STATUS    8'h10
`define XBP_OFF_CONFIG    8'h14

// control register fields
`define XBP_CTRL_W        6
`define XBP_CTRL_RST      6'h00
`define XBP_CTRL_SHOW     0
`define XBP_CTRL_DISADDR  1
`define XBP_CTRL_PIO6     2
`define XBP_CTRL_PIOZ     3
`define XBP_CTRL_VAL6     4
`define XBP_CTRL_VALZ     5

// command register fields
`define XBP_CMD_ADDR_HI   19
`define XBP_CMD_WRITE     20
`define XBP_CMD_LANE      21
`define XBP_CMD_SEL_LO    22
`define XBP_CMD_SEL_HI    23
`define XBP_CMD_INTMEM    24
`define XBP_SEL_LOWER     2'h1
`define XBP_SEL_UPPER     2'h2

// status register fields
`define XBP_ST_PEND       0
`define XBP_ST_HOLD       1
`define XBP_ST_ADDRESS_PHASE_STRAP       2
`define XBP_ST_SHOWN      3
`define XBP_ST_EMPTY      4
`define XBP_ST_FULL       5
`define XBP_ST_CYCLE      6
`define XBP_RD_VALID      8

// reset values of config capture, data and address
`define XBP_CFG_RST       16'h0000
`define XBP_DATA_RST      8'h00
`define XBP_ADDR_RST      20'h00000

`endif

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "xbp_map.vh"
module tb_top;
    logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RESET_INPUT_N, BUS_HOLD_REQ;
    logic        BUS_HOLD_ACK, PRIMARY_CLOCK_OUT, ADDRESS_PHASE_STRAP, SHOW_READ_STRAP_N, STATUS_SIX_OUT;
    logic        UPPER_ZERO_INDICATOR, ADDR_LATCH_ENABLE, READ_STROBE_N, LOW_BYTE_WRITE_STROBE_N;
    logic        NONMUX_ADDRESS_OE, MUXED_ADDR_DATA_LOW_OE, UPPER_ADDRESS_ONLY_BUS_OE;
    logic [7:0]  PADDR, MUXED_ADDR_DATA_LOW_IN, MUXED_ADDR_DATA_LOW_OUT;
    logic [7:0]  UPPER_ADDRESS_ONLY_BUS_IN, UPPER_ADDRESS_ONLY_BUS_OUT;
    logic [19:0] NONMUX_ADDRESS_BUS;
    logic [31:0] PWDATA, PRDATA, rdata;
    logic [15:0] cfg_value;
    logic        cfg_drive, slow, err, show_seen;
    int          n_mismatch, compares, n_ale, n, i;

    xbp_bus_pins dut (.*);
    xbp_ext_mem u_mem (
        .clk       (CLK),
        .slow      (slow),
        .cfg_drive (cfg_drive),
        .cfg_value (cfg_value),
        .low_out   (MUXED_ADDR_DATA_LOW_OUT),
        .low_oe    (MUXED_ADDR_DATA_LOW_OE),
        .up_out    (UPPER_ADDRESS_ONLY_BUS_OUT),
        .up_oe     (UPPER_ADDRESS_ONLY_BUS_OE),
        .ale       (ADDR_LATCH_ENABLE),
        .rd_n      (READ_STROBE_N),
        .wr_n      (LOW_BYTE_WRITE_STROBE_N),
        .low_level (MUXED_ADDR_DATA_LOW_IN),
        .up_level  (UPPER_ADDRESS_ONLY_BUS_IN)
    );
    // system clock, 100 ns period
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // count latch strobes and spot mirrored internal data on the pins
    always @(posedge CLK)
    begin
        n_ale <= n_ale + (ADDR_LATCH_ENABLE === 1'b1);
        if (MUXED_ADDR_DATA_LOW_OE === 1'b1 && MUXED_ADDR_DATA_LOW_OUT === 8'h99)
            show_seen <= 1'b1;
    end
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the slave sets its own pace, the watchdog guards it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CLK);
        while (PREADY !== 1'b1);
        rdata = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // poll until nothing is pending and no cycle runs
    task automatic idle();
        do
            apb(1'b0, `XBP_OFF_STATUS, 0);
        while ((rdata[0] | rdata[6]) !== 1'b0);
    endtask
    task automatic cyc(input logic wr, ln, input logic [1:0] sel, input logic im, input logic [19:0] a);
        apb(1'b1, `XBP_OFF_CMD, {7'h00, im, sel, ln, wr, a});
        idle();
    endtask
    // pulse the reset pin while the far side holds configuration on the pins
    task automatic pin_reset(input logic strap, input logic [15:0] cfg);
        RESET_INPUT_N <= 1'b0;
        ADDRESS_PHASE_STRAP <= strap;
        cfg_value <= cfg;
        cfg_drive <= 1'b1;
        repeat (4) @(posedge CLK);
        RESET_INPUT_N <= 1'b1;
        repeat (2) @(posedge CLK);
        cfg_drive <= 1'b0;
        apb(1'b0, `XBP_OFF_CONFIG, 0);
        chk(rdata, cfg);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // guard against a hang; the tests need well under 5000 cycles
    initial
    begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {SYS_RST, ADDRESS_PHASE_STRAP, SHOW_READ_STRAP_N} = 3'b111;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {RESET_INPUT_N, BUS_HOLD_REQ, slow, show_seen, cfg_drive, cfg_value} = '0;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        pin_reset(1'b1, 16'ha53c);
        apb(1'b0, 8'h18, 0);
        chk({err, rdata}, 33'h1_0000_0000);
        apb(1'b1, `XBP_OFF_CTRL, 32'h3c);
        apb(1'b0, `XBP_OFF_CTRL, 0);
        chk({STATUS_SIX_OUT, UPPER_ZERO_INDICATOR, rdata}, 34'h3_0000_003c);
        apb(1'b1, `XBP_OFF_CTRL, 0);
        apb(1'b1, `XBP_OFF_WDATA, 32'h5a);
        cyc(1'b1, 1'b1, 2'h0, 1'b0, 20'h12345);
        apb(1'b1, `XBP_OFF_WDATA, 32'h77);
        cyc(1'b1, 1'b0, 2'h0, 1'b0, 20'h00046);
        chk({u_mem.mem[8'h45], u_mem.mem[8'h46]}, 16'h5a46);
        slow <= 1'b1;
        cyc(1'b0, 1'b1, 2'h0, 1'b0, 20'h00045);
        cyc(1'b0, 1'b1, 2'h0, 1'b0, 20'h00046);
        apb(1'b0, `XBP_OFF_RDATA, 0);
        chk(rdata, 32'h15a);
        apb(1'b0, `XBP_OFF_RDATA, 0);
        chk(rdata, 32'h146);
        // internal reads, mirrored only with the show bit set
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, `XBP_OFF_CTRL, 32'(i));
            apb(1'b1, `XBP_OFF_WDATA, 32'h99);
            show_seen = 1'b0;
            cyc(1'b0, 1'b0, 2'h0, 1'b1, 20'h00010);
            apb(1'b0, `XBP_OFF_RDATA, 0);
            chk({show_seen, rdata}, {i[0], 32'h199});
        end
        // address phase dropped only for lower and upper selects
        apb(1'b1, `XBP_OFF_CTRL, 32'h2);
        for (i = 0; i < 3; i++)
        begin
            n = n_ale;
            cyc(1'b1, 1'b1, i[1:0], 1'b0, 20'h00050);
            chk(n_ale - n, i == 0);
        end
        BUS_HOLD_REQ <= 1'b1;
        repeat (4) @(posedge CLK);
        chk({BUS_HOLD_ACK, NONMUX_ADDRESS_OE, MUXED_ADDR_DATA_LOW_OE, UPPER_ADDRESS_ONLY_BUS_OE}, 4'h8);
        BUS_HOLD_REQ <= 1'b0;
        // fill the fifo with a slow far side, then one more read must wait
        for (i = 0; i < 8; i++)
            cyc(1'b0, 1'b0, 2'h0, 1'b0, {12'h000, 8'h80 + i[7:0]});
        apb(1'b1, `XBP_OFF_CMD, 32'h88);
        repeat (30) @(posedge CLK);
        apb(1'b0, `XBP_OFF_STATUS, 0);
        chk({rdata[5], rdata[4], rdata[0]}, 3'b101);
        for (i = 0; i < 9; i++)
        begin
            if (i == 8)
                idle();
            apb(1'b0, `XBP_OFF_RDATA, 0);
            chk(rdata, 32'h180 + i);
        end
        apb(1'b0, `XBP_OFF_STATUS, 0);
        chk(rdata[4], 1'b1);
        // straps low: status pins locked, address-disable ignored, internal reads shown
        SHOW_READ_STRAP_N <= 1'b0;
        pin_reset(1'b0, 16'h3cc3);
        apb(1'b1, `XBP_OFF_CTRL, 32'h3e);
        n = n_ale;
        cyc(1'b1, 1'b1, `XBP_SEL_LOWER, 1'b0, 20'h00051);
        chk({STATUS_SIX_OUT, UPPER_ZERO_INDICATOR, n_ale - n}, 34'h1_0000_0001);
        show_seen = 1'b0;
        cyc(1'b0, 1'b0, 2'h0, 1'b1, 20'h00010);
        chk(show_seen, 1'b1);
        end_of_test();
    end
endmodule
bind xbp_bus_pins xbp_pins_asserts #(.AW(AW)) u_chk (.*);
`default_nettype wire

// [verif/xbp_ext_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module xbp_ext_mem (
    input wire logic        clk,
    input wire logic        slow,
    input wire logic        cfg_drive,
    input wire logic [15:0] cfg_value,
    input wire logic [7:0]  low_out,
    input wire logic        low_oe,
    input wire logic [7:0]  up_out,
    input wire logic        up_oe,
    input wire logic        ale,
    input wire logic        rd_n,
    input wire logic        wr_n,
    output logic [7:0]      low_level,
    output logic [7:0]      up_level
);
    logic [7:0] mem [0:255];
    logic [7:0] addr;
    logic [7:0] last;
    logic [1:0] rd_cnt;
    logic       drive;
    // each byte starts as its own address, so reads need no setup
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i);
    end
    // address taken while the latch strobe is high, valid at its trailing edge
    always @(posedge clk)
    begin
        if (ale)
            addr <= low_out;
        if (!wr_n && low_oe)
            mem[addr] <= low_out;
        rd_cnt <= rd_n ? 2'd0 : rd_cnt + 2'd1;
        last <= low_level;
    end
    // a slow device answers only in the last strobe cycle, just in time for t3's end
    assign drive = !rd_n && (!slow || rd_cnt == 2'd3);
    // config held across the reset release; released low lines wander, released upper lines show the inverse of up_out
    assign low_level = low_oe ? low_out : cfg_drive ? cfg_value[7:0] : drive ? mem[addr] : ~last;
    assign up_level = up_oe ? up_out : cfg_drive ? cfg_value[15:8] : ~up_out;
endmodule
`default_nettype wire

// [verif/xbp_pins_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module xbp_pins_asserts #(
    parameter AW = 20
) (
    input wire logic          CLK,
    input wire logic          SYS_RST,
    input wire logic          RESET_INPUT_N,
    input wire logic          BUS_HOLD_ACK,
    input wire logic          PRIMARY_CLOCK_OUT,
    input wire logic [AW-1:0] NONMUX_ADDRESS_BUS,
    input wire logic          NONMUX_ADDRESS_OE,
    input wire logic [7:0]    MUXED_ADDR_DATA_LOW_OUT,
    input wire logic          MUXED_ADDR_DATA_LOW_OE,
    input wire logic [7:0]    UPPER_ADDRESS_ONLY_BUS_OUT,
    input wire logic          UPPER_ADDRESS_ONLY_BUS_OE,
    input wire logic          ADDR_LATCH_ENABLE,
    input wire logic          READ_STROBE_N,
    input wire logic          LOW_BYTE_WRITE_STROBE_N,
    input wire logic          ADDRESS_PHASE_STRAP,
    input wire logic          STATUS_SIX_OUT,
    input wire logic          UPPER_ZERO_INDICATOR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // short aliases keep the properties readable
    wire logic       mo = MUXED_ADDR_DATA_LOW_OE;
    wire logic [7:0] md = MUXED_ADDR_DATA_LOW_OUT;
    wire logic       wn = LOW_BYTE_WRITE_STROBE_N;
    wire logic       rn = READ_STROBE_N;
    wire logic       al = ADDR_LATCH_ENABLE;
    // strap as seen at the last release of the reset pin; a sync reset forces a fresh capture
    logic res_prev;
    logic locked;
    always_ff @(posedge CLK)
    begin
        res_prev <= SYS_RST ? 1'b0 : RESET_INPUT_N;
        locked   <= SYS_RST ? 1'b0 : (!res_prev && RESET_INPUT_N) ? !ADDRESS_PHASE_STRAP : locked;
    end
    sequence s_addr; mo && md == NONMUX_ADDRESS_BUS[7:0] && UPPER_ADDRESS_ONLY_BUS_OE
        && UPPER_ADDRESS_ONLY_BUS_OUT == NONMUX_ADDRESS_BUS[15:8]; endsequence
    sequence s_wr; (mo && !wn)[*4] ##1 (mo && wn && $stable(md))[*2] ##1 !mo; endsequence
    sequence s_rd; (!rn && !mo)[*2] ##1 (!rn)[*2] ##1 rn; endsequence
    property p_addr_float; BUS_HOLD_ACK || !(RESET_INPUT_N || $past(RESET_INPUT_N)) |-> !NONMUX_ADDRESS_OE; endproperty
    a_addr_float: assert property (p_addr_float) else $error("address bus driven in hold or reset");
    property p_mux_float; BUS_HOLD_ACK || !(RESET_INPUT_N || $past(RESET_INPUT_N)) |-> !mo && !UPPER_ADDRESS_ONLY_BUS_OE;
    endproperty
    a_mux_float: assert property (p_mux_float) else $error("muxed pins driven in hold or reset");
    property p_addr_phase; $rose(al) |-> s_addr; endproperty
    a_addr_phase: assert property (p_addr_phase) else $error("bad address phase");
    property p_addr_lead; $rose(al) |-> NONMUX_ADDRESS_OE && $stable(NONMUX_ADDRESS_BUS) && $rose(PRIMARY_CLOCK_OUT);
    endproperty
    a_addr_lead: assert property (p_addr_lead) else $error("address bus not half period early");
    property p_latch_valid; $rose(al) |=> !al && mo && $stable(md); endproperty
    a_latch_valid: assert property (p_latch_valid) else $error("address not held at latch fall");
    property p_wr_data; $fell(wn) |-> s_wr; endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data phase wrong");
    property p_rd_float; $fell(rn) |-> s_rd; endproperty
    a_rd_float: assert property (p_rd_float) else $error("read phase wrong");
    property p_strap_lock; locked && $past(locked) |-> !STATUS_SIX_OUT && UPPER_ZERO_INDICATOR; endproperty
    a_strap_lock: assert property (p_strap_lock) else $error("status pins left bus use");
endmodule
`default_nettype wire
